//--- rdc_device.sv
// processor end: block read response checking and line cache
// assumes agent keeps its side; one clock
`timescale 1ns/1ps
`include "rdc_consts.svh"
module rdc_device
   import rdc_pkg::*;
(
   input  wire logic                   REF_CLK,
   input  wire logic                   RESET_N,
   rdc_if.dev                          LINK,
   input  wire logic                   FETCH,
   input  wire logic [`RDC_PC_W-1:0]   FETCH_PC,
   input  wire logic                   CACHE_RD,
   input  wire logic [`RDC_WIDX_W-1:0] CACHE_IDX,
   output logic                        READ_REQ,
   output logic                        BUS_ERR_EXC,
   output logic                        CACHE_ERR_EXC,
   output logic [`RDC_ERR_W-1:0]       CACHE_ERR_REG,
   output logic [`RDC_PC_W-1:0]        ERROR_RETURN_PC,
   output logic [`RDC_DATA_W-1:0]      CACHE_RD_DATA,
   output logic                        CACHE_RD_VALID,
   output logic                        LINE_DONE
);
   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed {
      rdc_state_t                 st;
      logic [`RDC_WIDX_W-1:0]     widx;
      logic [`RDC_PC_W-1:0]       pc;
      logic                       req;
      logic                       bus_exc;
      logic                       cache_exc;
      logic [`RDC_ERR_W-1:0]      err;
      logic [`RDC_PC_W-1:0]       epc;
      logic [`RDC_DATA_W-1:0]     rd_data;
      logic                       rd_valid;
      logic                       done;
   } rdc_dev_t;
   rdc_dev_t s_r;
   rdc_dev_t s_nxt;
   rdc_word_t mem_data [`RDC_LINE_WORDS];
   rdc_chk_t  mem_par  [`RDC_LINE_WORDS];
   logic      wr_en;
   rdc_chk_t  wr_par;
   logic      good_n;
   logic      dce;
   logic      par_bad;
   logic      last_word;
   logic [`RDC_LINE_WORDS-1:0] ent_bad;
   // error register image: source flag plus word index
   function automatic logic [`RDC_ERR_W-1:0] err_word(
      input int unsigned            src_bit,
      input logic [`RDC_WIDX_W-1:0] idx);
      logic [`RDC_ERR_W-1:0] e;
      e = '0;
      e[src_bit] = 1'b1;
      e[`RDC_ERR_IDX_LSB +: `RDC_WIDX_W] = idx;
      return e;
   endfunction
   //------------------------------------------------------------
   // response decode
   //------------------------------------------------------------
   // command parity never looked at (see RULE15) (see RULE16)
   assign good_n  = LINK.system_command_bus[`RDC_GOOD_BIT]; // see RULE1
   assign dce     = LINK.system_command_bus[`RDC_DCE_BIT];  // see RULE2
   assign par_bad = rdc_parity(LINK.system_address_data_bus)
                    != LINK.bus_check_bits;
   // enable one: internal parity, else bus parity kept (see RULE9)
   assign wr_par  = dce ? rdc_parity(LINK.system_address_data_bus)
                        : LINK.bus_check_bits; // see RULE6
   assign last_word = s_r.widx == `RDC_WIDX_W'(`RDC_LINE_WORDS - 1);
   always_comb begin
      wr_en = 1'b0;
      if (LINK.read_data_valid_in) begin
         unique case (s_r.st)
            RDC_FIRST: wr_en = !good_n;
            RDC_REST:  wr_en = 1'b1; // see RULE4
            default:   wr_en = 1'b0;
         endcase
      end
   end
   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      s_nxt           = s_r;
      s_nxt.bus_exc   = 1'b0;
      s_nxt.cache_exc = 1'b0;
      s_nxt.rd_valid  = 1'b0;
      s_nxt.done      = 1'b0;
      unique case (s_r.st)
         RDC_IDLE: begin
            if (FETCH) begin
               s_nxt.req  = 1'b1;
               s_nxt.pc   = FETCH_PC;
               s_nxt.widx = '0;
               s_nxt.st   = RDC_FIRST;
            end
         end
         RDC_FIRST: begin
            s_nxt.req = 1'b0;
            if (LINK.read_data_valid_in) begin
               if (good_n) begin
                  s_nxt.bus_exc = 1'b1; // see RULE3
                  s_nxt.epc     = s_r.pc;
                  s_nxt.st      = RDC_IDLE;
               end else begin
                  if (!dce && par_bad) begin
                     s_nxt.cache_exc = 1'b1; // see RULE5
                     s_nxt.err = err_word(`RDC_ERR_SRC_BIT, '0);
                     s_nxt.epc = s_r.pc; // see RULE7
                  end
                  s_nxt.widx = s_r.widx + 1'b1;
                  s_nxt.st   = RDC_REST;
               end
            end
         end
         RDC_REST: begin
            if (LINK.read_data_valid_in) begin
               s_nxt.widx = s_r.widx + 1'b1;
               if (last_word) begin
                  s_nxt.done = 1'b1;
                  s_nxt.st   = RDC_IDLE;
               end
            end
         end
         default: s_nxt.st = RDC_IDLE;
      endcase
      if (CACHE_RD) begin
         s_nxt.rd_data  = mem_data[CACHE_IDX];
         s_nxt.rd_valid = 1'b1;
         if (ent_bad[CACHE_IDX]) begin // see RULE14
            s_nxt.cache_exc = 1'b1; // see RULE6
            s_nxt.err = err_word(`RDC_ERR_DATA_BIT, CACHE_IDX); // see RULE7
            s_nxt.epc = s_r.pc;
         end
      end
   end
   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_r <= '{st: RDC_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end
   //------------------------------------------------------------
   // cache array, one entry per word
   //------------------------------------------------------------
   for (genvar g = 0; g < `RDC_LINE_WORDS; g++) begin : g_ent
      logic ent_wr;
      assign ent_wr = wr_en && (s_r.widx == `RDC_WIDX_W'(g));
      always_ff @(posedge REF_CLK) begin
         if (ent_wr) begin
            mem_data[g] <= LINK.system_address_data_bus;
            mem_par[g]  <= wr_par; // see RULE6
         end
      end
      // stored parity tested on each read (see RULE14)
      assign ent_bad[g] = rdc_parity(mem_data[g]) != mem_par[g];
   end
   //------------------------------------------------------------
   // outputs
   //------------------------------------------------------------
   assign LINK.read_req   = s_r.req;
   assign READ_REQ        = s_r.req;
   assign BUS_ERR_EXC     = s_r.bus_exc;
   assign CACHE_ERR_EXC   = s_r.cache_exc;
   assign CACHE_ERR_REG   = s_r.err;
   assign ERROR_RETURN_PC = s_r.epc;
   assign CACHE_RD_DATA   = s_r.rd_data;
   assign CACHE_RD_VALID  = s_r.rd_valid;
   assign LINE_DONE       = s_r.done;
endmodule

//--- rdc_consts.svh
// constants for the read response data check block
// assumes inclusion by the package and both ends
`ifndef RDC_CONSTS_SVH
`define RDC_CONSTS_SVH
//------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------
// Notes on behaviour
// RULE1 - command bit five: good-data flag, active low
// RULE2 - command bit four: data-checking enable, agent driven
// RULE3 - bad flag on first word: bus error
// RULE4 - good-data flag ignored after first word
// RULE5 - first word parity bad: cache error, bit 26
// RULE6 - later bad parity stored, raised on access
// RULE7 - error pc and register locate the fault
// RULE8 - agent checking itself drives enable one
// RULE9 - enable one: parity generated, stored, checked
// RULE10 - agent may flag first word bad
// RULE11 - later word errors reported by interrupt
// RULE12 - agent may retry, valid only clean data
// RULE13 - no memory parity: enable one, flag zero
// RULE14 - stored parity tested on every cache read
// RULE15 - no parity check on command bus
// RULE16 - command parity ignored in slave state
//------------------------------------------------------------
`define RDC_DATA_W      64
`define RDC_CHK_W       8
`define RDC_CMD_W       9
`define RDC_GOOD_BIT    5
`define RDC_DCE_BIT     4
`define RDC_ERR_W       32
`define RDC_ERR_SRC_BIT 26
`define RDC_ERR_DATA_BIT 30
`define RDC_ERR_IDX_LSB 0
`define RDC_LINE_WORDS  4
`define RDC_WIDX_W      2
`define RDC_PC_W        32
`endif

//--- rdc_pkg.sv
// types for the read response data check block
// assumes rdc_consts.svh on the include path
`include "rdc_consts.svh"
package rdc_pkg;
   typedef logic [`RDC_DATA_W-1:0] rdc_word_t;
   typedef logic [`RDC_CHK_W-1:0]  rdc_chk_t;
   typedef logic [`RDC_CMD_W-1:0]  rdc_cmd_t;
   typedef enum logic [1:0] {
      RDC_IDLE  = 2'b00,
      RDC_FIRST = 2'b01,
      RDC_REST  = 2'b11
   } rdc_state_t;
   typedef enum logic [1:0] {
      RDC_AG_IDLE = 2'b00,
      RDC_AG_WAIT = 2'b01,
      RDC_AG_SEND = 2'b11
   } rdc_ag_state_t;
   function automatic rdc_chk_t rdc_parity(input rdc_word_t w);
      rdc_chk_t p;
      p = '0;
      for (int i = 0; i < `RDC_CHK_W; i++) begin
         p[i] = ^w[i*8 +: 8];
      end
      return p;
   endfunction
endpackage

//--- rdc_if.sv
// system bus link between processor end and external agent
// assumes one shared clock and reset
`timescale 1ns/1ps
interface rdc_if (input wire logic REF_CLK);
   import rdc_pkg::*;
   logic     read_req;
   logic     read_data_valid_in;
   rdc_word_t system_address_data_bus;
   rdc_chk_t bus_check_bits;
   rdc_cmd_t system_command_bus;
   logic     command_bus_parity;
   modport dev (input read_data_valid_in, system_address_data_bus,
                bus_check_bits, system_command_bus,
                command_bus_parity, output read_req);
   modport agent (output read_data_valid_in, system_address_data_bus,
                  bus_check_bits, system_command_bus,
                  command_bus_parity, input read_req);
endinterface

//--- rdc_agent.sv
// external agent end: returns a line, qualifies each word
// assumes memory words supplied on the user side
`timescale 1ns/1ps
`include "rdc_consts.svh"
module rdc_agent
   import rdc_pkg::*;
(
   input  wire logic                   REF_CLK,
   input  wire logic                   RESET_N,
   rdc_if.agent                        LINK,
   input  wire logic                   MEM_HAS_PARITY,
   input  wire logic                   MEM_VALID,
   input  wire logic [`RDC_DATA_W-1:0] MEM_DATA,
   input  wire logic [`RDC_CHK_W-1:0]  MEM_CHK,
   output logic                        MEM_REQ,
   output logic                        LATER_ERR_NMI
);
   //------------------------------------------------------------
   // state
   //------------------------------------------------------------
   typedef struct packed {
      rdc_ag_state_t              st;
      logic [`RDC_WIDX_W-1:0]     widx;
      logic                       valid;
      rdc_word_t                  data;
      rdc_chk_t                   chk;
      rdc_cmd_t                   cmd;
      logic                       mreq;
      logic                       nmi;
   } rdc_ag_t;
   rdc_ag_t s_r;
   rdc_ag_t s_nxt;
   logic    mem_bad;
   assign mem_bad = MEM_HAS_PARITY && (rdc_parity(MEM_DATA) != MEM_CHK);
   //------------------------------------------------------------
   // next state
   //------------------------------------------------------------
   always_comb begin
      s_nxt       = s_r;
      s_nxt.valid = 1'b0;
      s_nxt.nmi   = 1'b0;
      s_nxt.mreq  = 1'b0;
      s_nxt.cmd   = '0;
      unique case (s_r.st)
         RDC_AG_IDLE: begin
            if (LINK.read_req) begin
               s_nxt.widx = '0;
               s_nxt.mreq = 1'b1;
               s_nxt.st   = RDC_AG_WAIT;
            end
         end
         RDC_AG_WAIT: begin
            if (MEM_VALID) begin
               s_nxt.data  = MEM_DATA;
               s_nxt.chk   = MEM_CHK;
               s_nxt.valid = 1'b1;
               // own checking, memory check bits still passed on (see RULE8) (see RULE13)
               s_nxt.cmd[`RDC_DCE_BIT] = 1'b1; // see RULE2
               if (mem_bad && s_r.widx == '0) begin
                  s_nxt.cmd[`RDC_GOOD_BIT] = 1'b1; // see RULE1, see RULE10
                  s_nxt.st = RDC_AG_IDLE;
               end else begin
                  if (mem_bad) begin
                     s_nxt.nmi = 1'b1; // see RULE11
                  end
                  s_nxt.st = RDC_AG_SEND;
               end
            end else begin
               s_nxt.mreq = 1'b1;
            end
         end
         RDC_AG_SEND: begin
            // each word sent once, no retry (see RULE12)
            s_nxt.widx = s_r.widx + 1'b1;
            if (s_r.widx == `RDC_WIDX_W'(`RDC_LINE_WORDS - 1)) begin
               s_nxt.st = RDC_AG_IDLE;
            end else begin
               s_nxt.mreq = 1'b1;
               s_nxt.st   = RDC_AG_WAIT;
            end
         end
         default: s_nxt.st = RDC_AG_IDLE;
      endcase
   end
   //------------------------------------------------------------
   // registers
   //------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s_r <= '{st: RDC_AG_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end
   assign LINK.read_data_valid_in      = s_r.valid;
   assign LINK.system_address_data_bus = s_r.data;
   assign LINK.bus_check_bits          = s_r.chk;
   assign LINK.system_command_bus      = s_r.cmd;
   assign LINK.command_bus_parity      = 1'b0;
   assign MEM_REQ                      = s_r.mreq;
   assign LATER_ERR_NMI                = s_r.nmi;
endmodule

//--- rdc_link_props.sv
// checker for the link joining the two ends
// assumes one clock and reset; instantiated beside the interface
`timescale 1ns/1ps
`include "rdc_consts.svh"
module rdc_link_props
   import rdc_pkg::*;
(
   input wire logic      REF_CLK,
   input wire logic      RESET_N,
   input wire logic      read_req,
   input wire logic      read_data_valid_in,
   input wire rdc_word_t system_address_data_bus,
   input wire rdc_chk_t  bus_check_bits,
   input wire rdc_cmd_t  system_command_bus,
   input wire logic      command_bus_parity
);
   logic [2:0] cnt_r;
   logic       act_r;
   logic       bad_w;
   assign bad_w = system_command_bus[`RDC_GOOD_BIT];
   // word count of the line in flight
   always_ff @(posedge REF_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_r <= 3'h0;
         act_r <= 1'b0;
      end else if (read_req) begin
         cnt_r <= 3'h0;
         act_r <= 1'b1;
      end else if (read_data_valid_in) begin
         cnt_r <= cnt_r + 3'h1;
         if (cnt_r == 3'h3 || bad_w) act_r <= 1'b0;
      end
   end
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESET_N);
   chk_dce_set: assert property (
      read_data_valid_in |-> system_command_bus[`RDC_DCE_BIT])
      else $error("data check enable low on a word");
   chk_flag_first: assert property (
      read_data_valid_in && bad_w |-> cnt_r == 3'h0)
      else $error("bad flag on a later word");
   chk_bad_aborts: assert property (
      read_data_valid_in && bad_w |=> (!read_data_valid_in) [*3])
      else $error("words sent after bad first word");
   chk_words_in: assert property (
      read_data_valid_in |-> act_r && cnt_r < 3'h4)
      else $error("word outside a line");
   chk_cmd_par: assert property (
      command_bus_parity == 1'b0)
      else $error("command parity driven");
   chk_req_pulse: assert property (read_req |=> (!read_req) [*4])
      else $error("request not a single pulse");
   chk_answer_soon: assert property (
      read_req |-> ##[1:40] read_data_valid_in)
      else $error("no word after request");
   chk_req_idle: assert property (read_req |-> !act_r)
      else $error("request while line busy");
   cov_bad_first: cover property (read_data_valid_in && bad_w);
   cov_full_line: cover property (read_data_valid_in && cnt_r == 3'h3);
   cov_req: cover property (read_req);
endmodule

//--- tb_read_response_data_check.sv
// bench joining device and agent ends, memory modelled here
// assumes rdc_consts.svh on the include path
`timescale 1ns/1ps
`include "rdc_consts.svh"
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin \
   mismatches++; $display("[ERR] %s exp %h seen %h", n, e, s); end end
module tb_read_response_data_check;
   import rdc_pkg::*;
   logic clk = 0, rst_n = 0, fetch = 0, cache_rd = 0, has_par = 1;
   logic mem_valid = 0, mem_req, rd_valid, berr, cerr, done, nmi, req;
   logic [31:0] epc, err_reg;
   bit          hung = 1'b0;
   rdc_word_t   exp_w;
   logic [31:0] pc = 0;
   logic [1:0]  idx = 0;
   rdc_word_t   mem_data = '0, rd_data;
   rdc_chk_t    mem_chk = '0;
   rdc_word_t   line [4];
   rdc_word_t   exp_q [$];
   int mismatches = 0, samples_checked = 0, seed = 32'h0786;
   int widx = 0, bad_idx = 4, n_done, n_berr, n_cerr, n_nmi, n_req;
   initial forever #2 clk = ~clk;
   rdc_if link_if (.REF_CLK(clk));
   rdc_device rdc_device_inst (.REF_CLK(clk), .RESET_N(rst_n),
      .LINK(link_if), .FETCH(fetch), .FETCH_PC(pc), .CACHE_RD(cache_rd),
      .CACHE_IDX(idx), .READ_REQ(req), .BUS_ERR_EXC(berr),
      .CACHE_ERR_EXC(cerr), .CACHE_ERR_REG(err_reg), .ERROR_RETURN_PC(epc),
      .CACHE_RD_DATA(rd_data), .CACHE_RD_VALID(rd_valid), .LINE_DONE(done));
   rdc_agent rdc_agent_inst (.REF_CLK(clk), .RESET_N(rst_n), .LINK(link_if),
      .MEM_HAS_PARITY(has_par), .MEM_VALID(mem_valid), .MEM_DATA(mem_data),
      .MEM_CHK(mem_chk), .MEM_REQ(mem_req), .LATER_ERR_NMI(nmi));
   rdc_link_props rdc_link_props_inst (.REF_CLK(clk), .RESET_N(rst_n),
      .read_req(link_if.read_req),
      .read_data_valid_in(link_if.read_data_valid_in),
      .system_address_data_bus(link_if.system_address_data_bus),
      .bus_check_bits(link_if.bus_check_bits),
      .system_command_bus(link_if.system_command_bus),
      .command_bus_parity(link_if.command_bus_parity));
   //------------------------------------------------------------
   // memory answer and output watcher
   //------------------------------------------------------------
   function automatic rdc_chk_t par(input rdc_word_t w);
      for (int i = 0; i < 8; i++) par[i] = ^w[i*8 +: 8];
   endfunction
   always @(negedge clk) begin
      if (mem_req === 1'b1 && !mem_valid && widx < 4) begin
         mem_valid = 1'b1;
         mem_data = line[widx];
         mem_chk = par(line[widx]) ^ ((widx == bad_idx) ? 8'h01 : 8'h00);
         widx++;
      end else mem_valid = 1'b0;
   end
   always @(negedge clk) begin
      if (done === 1'b1) n_done++;
      if (berr === 1'b1) n_berr++;
      if (cerr === 1'b1) n_cerr++;
      if (nmi === 1'b1) n_nmi++;
      if (req === 1'b1) n_req++;
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) `CHK("extra_read", 1'b0, 1'b1)
         else begin
            exp_w = exp_q.pop_front();
            `CHK("cache_rd_data", exp_w, rd_data)
         end
      end
   end
   task automatic print_verdict();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic fetch_line(input int bad, input int e_done, e_berr, e_nmi);
      int t;
      if (hung) return;
      widx = 0;
      bad_idx = bad;
      for (int i = 0; i < 4; i++) line[i] = {$random(seed), $random(seed)};
      n_done = 0;
      n_berr = 0;
      n_nmi = 0;
      n_req = 0;
      @(negedge clk) fetch = 1'b1;
      pc = $random(seed);
      @(negedge clk) fetch = 1'b0;
      for (t = 0; t < 100 && n_done == 0 && n_berr == 0; t++) @(negedge clk);
      if (t == 100) begin
         mismatches++;
         hung = 1'b1;
         return;
      end
      repeat (4) @(negedge clk);
      `CHK("line_done", e_done, n_done)
      `CHK("bus_err", e_berr, n_berr)
      `CHK("later_nmi", e_nmi, n_nmi)
      `CHK("read_req", 1, n_req)
      if (e_berr != 0) `CHK("error_pc", pc, epc)
   endtask
   task automatic read_word(input int i);
      if (hung) return;
      @(negedge clk) cache_rd = 1'b1;
      idx = i[1:0];
      exp_q.push_back(line[i]);
      @(negedge clk) cache_rd = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   //------------------------------------------------------------
   // main sequence
   //------------------------------------------------------------
   initial begin
      n_cerr = 0;
      repeat (2) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      fetch_line(4, 1, 0, 0);
      for (int i = 0; i < 4; i++) read_word(i);
      fetch_line(0, 0, 1, 0);
      for (int k = 1; k < 4; k++) begin
         fetch_line(k, 1, 0, 1);
         read_word(k);
      end
      has_par = 1'b0;
      fetch_line(0, 1, 0, 0);
      read_word(0);
      `CHK("cache_err", 0, n_cerr)
      `CHK("cache_err_reg", 32'h0, err_reg)
      `CHK("reads_left", 0, exp_q.size())
      print_verdict();
   end
endmodule
